//--- design/tx_modulation_config_regs.sv
// Purpose: Modem configuration registers behind the serial register port,
//          with the transmit option decode they steer.
// Assumes: Port pins are asynchronous; tx strobes and results come from clk.
// Notes:   Mode 0 serial port, MSB first, first bit set means write.
//
// Overview of operation
// - Rate low byte resets to 0x0D, so with upper byte 0x0A the word 0x0A0D gives 39.26 kbps.
// - Rate is 1000 times word over 2^16, or 2^21 when scaled.
// - Packet handler powers down in low power when its bit is set.
// - Manchester preamble sends ones if polarity set, zeros otherwise; receive unaffected.
// - Manchester inversion bit inverts Manchester-coded data.
// - Manchester enable bit switches Manchester coding on or off.
// - Whitening enable bit applies data whitening.
// - Clock field routes transmit clock to none, GPIO, serial out, interrupt pin.
// - Source field picks GPIO, serial in while deselected, FIFO or PN9.
// - Data inversion bit inverts both transmit and receive data.
// - Type field selects carrier, OOK, FSK or GFSK.
// - Deviation is 625 Hz times nine-bit value across two registers.
// - Offset is 156.25 Hz times band factor times ten-bit signed value.
// - Reading either offset register returns the latest correction result.
// - High band select doubles the offset step size.
`timescale 1ns/10ps
`include "tx_mod_map.svh"
module tx_modulation_config_regs (
   input wire logic clk, // System clock, 125 MHz.
   input wire logic resetn, // Synchronous reset, active low.
   input wire logic chip_select_pin_n, // Serial port select, active low.
   input wire logic sck_pin, // Serial port clock.
   input wire logic sdi_pin, // Serial port data in.
   output logic sdo_pin, // Serial port data out.
   output logic sdo_oe_n, // Data out enable, low while driven.
   input wire logic [7:0] tx_rate_high, // Upper rate byte held elsewhere.
   input wire logic high_band, // High band select.
   input wire logic low_power_mode, // Device sits in a low power mode.
   input wire logic [9:0] afc_result, // Latest frequency correction result.
   input wire logic tx_bit_strobe, // One-cycle pulse per transmit bit.
   input wire logic tx_clk_level, // Transmit data clock level.
   input wire logic preamble_phase, // Transmitter is sending preamble.
   input wire logic gpio_tx_data, // Direct data from a GPIO pin.
   input wire logic fifo_tx_data, // Data bit from the transmit FIFO.
   input wire logic rx_data_in, // Demodulated receive bit.
   input wire logic irq_source_n, // Interrupt request, active low.
   output logic [15:0] tx_rate_word, // Combined rate setting.
   output logic rate_scale, // Rate divisor is 2^21 when set.
   output logic ph_power_down, // Packet handler power-down.
   output logic manchester_en, // Manchester coding active.
   output logic whiten_en, // Whitening active.
   output tx_mod_pkg::modtyp_e mod_type, // Selected modulation.
   output tx_mod_pkg::trclk_e trclk_sel, // Transmit clock routing.
   output tx_mod_pkg::dtmod_e dtmod_sel, // Transmit data source.
   output logic [8:0] deviation_value, // Deviation in 625 Hz steps.
   output logic [9:0] offset_value, // Programmed offset, two's complement.
   output logic [10:0] offset_scaled, // Offset in 156.25 Hz steps.
   output logic tx_data_out, // Coded transmit bit to modulator.
   output logic rx_data_out, // Receive bit after inversion.
   output logic txclk_gpio, // Transmit clock for a GPIO pin.
   output logic interrupt_pin_n // Interrupt pin, active low.
);
   import tx_mod_pkg::*;

   regs_s q;
   regs_s n;
   logic [2:0] pins_s;
   logic cs_n_s;
   logic sck_s;
   logic sdi_s;
   logic rise;
   logic fall;
   logic [7:0] wr_byte;
   logic src_bit;
   logic coded_bit;

   // -------------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------------
   // Select idles high, clock and data idle low in mode 0.
   pin_sync u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .pin_in({chip_select_pin_n, sck_pin, sdi_pin}),
      .idle_val(3'h4),
      .pin_out(pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign sdi_s = pins_s[0];
   assign rise = sck_s & ~q.sck_prev;
   assign fall = ~sck_s & q.sck_prev;
   assign wr_byte = {q.in_shift[6:0], sdi_s};

   // -------------------------------------------------------------------------
   // Register read-back
   // -------------------------------------------------------------------------
   // Unmapped addresses belong to other blocks and read as zero here.
   function automatic logic [7:0] read_reg(input logic [6:0] a, input regs_s s,
                                           input logic [9:0] afc);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `ADDR_RATE_LO: v = s.rate_lo;
         `ADDR_MOD_CTL1: v = s.ctl1 & `CTL1_USED_MASK;
         `ADDR_MOD_CTL2: v = s.ctl2;
         `ADDR_DEV_LO: v = s.dev_lo;
         `ADDR_OFS_LO: v = afc[7:0];
         `ADDR_OFS_HI: v = {6'h00, afc[9:8]};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // -------------------------------------------------------------------------
   // Transmit data path
   // -------------------------------------------------------------------------
   // source selection
   always_comb begin
      case (dtmod_e'(q.ctl2[`CTL2_DTMOD_HI:`CTL2_DTMOD_LO]))
         SRC_GPIO: src_bit = gpio_tx_data;
         SRC_SDI: src_bit = cs_n_s & sdi_s; // Serial input counts only while deselected.
         SRC_FIFO: src_bit = fifo_tx_data;
         SRC_PN9: src_bit = q.pn9[0];
         default: src_bit = 1'b0;
      endcase
   end

   // Whitening, Manchester inversion and preamble forcing, then data inversion.
   always_comb begin
      coded_bit = src_bit;
      if (q.ctl1[`CTL1_WHITE_EN]) begin
         coded_bit = coded_bit ^ q.white[0];
      end
      if (q.ctl1[`CTL1_MAN_EN]) begin
         if (q.ctl1[`CTL1_MAN_INV]) begin
            coded_bit = ~coded_bit;
         end
         if (preamble_phase) begin
            coded_bit = q.ctl1[`CTL1_PRE_POL];
         end
      end
      coded_bit = coded_bit ^ q.ctl2[`CTL2_DATA_INV];
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      n = q;
      n.sck_prev = sck_s;

      // Serial port framing: one address byte, then data bytes in a burst.
      if (cs_n_s) begin
         n.phase = PH_IDLE;
         n.bit_cnt = 3'h0;
      end else begin
         if (q.phase == PH_IDLE) begin
            n.phase = PH_ADDR;
         end
         if (rise) begin
            n.in_shift = wr_byte;
            n.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == `SPI_LAST_BIT) begin
               if (q.phase == PH_DATA) begin
                  if (q.is_write == `RW_BIT_WRITE) begin
                     case (q.addr)
                        `ADDR_RATE_LO: n.rate_lo = wr_byte;
                        `ADDR_MOD_CTL1: n.ctl1 = wr_byte & `CTL1_USED_MASK;
                        `ADDR_MOD_CTL2: n.ctl2 = wr_byte;
                        `ADDR_DEV_LO: n.dev_lo = wr_byte;
                        `ADDR_OFS_LO: n.ofs[7:0] = wr_byte;
                        `ADDR_OFS_HI: n.ofs[9:8] = wr_byte[1:0];
                        default: n.ofs = q.ofs;
                     endcase
                  end
                  n.addr = q.addr + 7'h01;
                  n.rd_shift = read_reg(q.addr + 7'h01, q, afc_result);
               end else begin
                  n.is_write = q.in_shift[6];
                  n.addr = wr_byte[6:0];
                  n.rd_shift = read_reg(wr_byte[6:0], q, afc_result);
                  n.phase = PH_DATA;
               end
            end
         end
         // Data out changes on falling edges so it is settled for the host.
         if (fall && q.phase == PH_DATA) begin
            n.sdo = q.rd_shift[7];
            n.rd_shift = {q.rd_shift[6:0], 1'b0};
         end
      end

      if (!cs_n_s) begin
         n.sdo_oe_n = 1'b0;
      end else if (trclk_e'(q.ctl2[`CTL2_TRCLK_HI:`CTL2_TRCLK_LO]) == TRCLK_SDO) begin
         n.sdo_oe_n = 1'b0;
         n.sdo = tx_clk_level;
      end else begin
         n.sdo_oe_n = 1'b1;
         n.sdo = 1'b0;
      end
      n.txclk_gpio = (q.ctl2[`CTL2_TRCLK_HI:`CTL2_TRCLK_LO] == TRCLK_GPIO) & tx_clk_level;
      if (trclk_e'(q.ctl2[`CTL2_TRCLK_HI:`CTL2_TRCLK_LO]) == TRCLK_IRQ) begin
         n.irq_pin = tx_clk_level;
      end else begin
         n.irq_pin = irq_source_n;
      end

      // Sequence generators advance once per transmitted bit.
      if (tx_bit_strobe) begin
         n.pn9 = {q.pn9[0] ^ q.pn9[5], q.pn9[8:1]};
         n.white = {q.white[0] ^ q.white[5], q.white[8:1]};
      end
      if (tx_bit_strobe && preamble_phase) begin
         n.white = `WHITE_SEED;
      end

      n.rate_word = {tx_rate_high, q.rate_lo};
      n.ph_pwdn = q.ctl1[`CTL1_PH_PWDN] & low_power_mode;
      n.dev_word = {q.ctl2[`CTL2_DEV_MSB], q.dev_lo};
      if (high_band) begin
         n.ofs_scaled = {q.ofs, 1'b0};
      end else begin
         n.ofs_scaled = {q.ofs[9], q.ofs};
      end
      n.tx_bit = coded_bit;
      n.rx_bit = rx_data_in ^ q.ctl2[`CTL2_DATA_INV];
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= '0;
         q.phase <= PH_IDLE;
         q.sck_prev <= 1'b0;
         q.sdo_oe_n <= 1'b1;
         q.rate_lo <= `RST_RATE_LO;
         q.ctl1 <= `RST_MOD_CTL1;
         q.ctl2 <= `RST_MOD_CTL2;
         q.dev_lo <= `RST_DEV_LO;
         q.ofs <= 10'({`RST_OFS_HI, `RST_OFS_LO});
         q.pn9 <= `PN9_SEED;
         q.white <= `WHITE_SEED;
         q.rate_word <= 16'h000D;
         q.dev_word <= 9'h020;
         q.irq_pin <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all taken from the state register
   // -------------------------------------------------------------------------
   // rate scaling bit
   assign rate_scale = q.ctl1[`CTL1_RATE_SCALE];
   assign sdo_pin = q.sdo;
   assign sdo_oe_n = q.sdo_oe_n;
   assign tx_rate_word = q.rate_word;
   assign ph_power_down = q.ph_pwdn;
   assign manchester_en = q.ctl1[`CTL1_MAN_EN];
   assign whiten_en = q.ctl1[`CTL1_WHITE_EN];
   assign mod_type = modtyp_e'(q.ctl2[`CTL2_MODTYP_HI:`CTL2_MODTYP_LO]);
   assign trclk_sel = trclk_e'(q.ctl2[`CTL2_TRCLK_HI:`CTL2_TRCLK_LO]);
   assign dtmod_sel = dtmod_e'(q.ctl2[`CTL2_DTMOD_HI:`CTL2_DTMOD_LO]);
   assign deviation_value = q.dev_word;
   assign offset_value = q.ofs;
   assign offset_scaled = q.ofs_scaled;
   assign tx_data_out = q.tx_bit;
   assign rx_data_out = q.rx_bit;
   assign txclk_gpio = q.txclk_gpio;
   assign interrupt_pin_n = q.irq_pin;
endmodule

//--- design/tx_mod_map.svh
// Purpose: Offsets, reset values, field positions and constants of the modem
//          configuration register group.
// Assumes: Seven-bit register addresses on the serial register port.
// Notes:   Definitions only; included by the main module.
`ifndef TX_MOD_MAP_SVH
`define TX_MOD_MAP_SVH

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define ADDR_RATE_LO 7'h6F
`define ADDR_MOD_CTL1 7'h70
`define ADDR_MOD_CTL2 7'h71
`define ADDR_DEV_LO 7'h72
`define ADDR_OFS_LO 7'h73
`define ADDR_OFS_HI 7'h74

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define RST_RATE_LO 8'h0D
`define RST_MOD_CTL1 8'h0C
`define RST_MOD_CTL2 8'h00
`define RST_DEV_LO 8'h20
`define RST_OFS_LO 8'h00
`define RST_OFS_HI 8'h00

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define CTL1_RATE_SCALE 5
`define CTL1_PH_PWDN 4
`define CTL1_PRE_POL 3
`define CTL1_MAN_INV 2
`define CTL1_MAN_EN 1
`define CTL1_WHITE_EN 0
`define CTL1_USED_MASK 8'h3F
`define CTL2_TRCLK_HI 7
`define CTL2_TRCLK_LO 6
`define CTL2_DTMOD_HI 5
`define CTL2_DTMOD_LO 4
`define CTL2_DATA_INV 3
`define CTL2_DEV_MSB 2
`define CTL2_MODTYP_HI 1
`define CTL2_MODTYP_LO 0
`define OFS_HI_USED_MASK 8'h03

// -----------------------------------------------------------------------------
// Serial framing and sequence constants
// -----------------------------------------------------------------------------
`define SPI_LAST_BIT 3'h7
`define RW_BIT_WRITE 1'b1
`define PN9_SEED 9'h1FF
`define WHITE_SEED 9'h1FF

`endif

//--- design/tx_mod_pkg.sv
// Purpose: Types shared by the modem configuration register group.
// Assumes: Constants come from the map header.
// Notes:   Enumerations mirror the two-bit selector fields.
package tx_mod_pkg;

   // --------------------------------------------------------------------------
   // Selector encodings
   // --------------------------------------------------------------------------
   typedef enum logic [1:0] {
      TRCLK_NONE = 2'b00,
      TRCLK_GPIO = 2'b01,
      TRCLK_SDO = 2'b10,
      TRCLK_IRQ = 2'b11
   } trclk_e;

   typedef enum logic [1:0] {
      SRC_GPIO = 2'b00,
      SRC_SDI = 2'b01,
      SRC_FIFO = 2'b10,
      SRC_PN9 = 2'b11
   } dtmod_e;

   typedef enum logic [1:0] {
      MOD_CARRIER = 2'b00,
      MOD_OOK = 2'b01,
      MOD_FSK = 2'b10,
      MOD_GFSK = 2'b11
   } modtyp_e;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b10
   } spi_phase_e;

   // --------------------------------------------------------------------------
   // Module state records
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] stable;
   } sync_s;

   typedef struct packed {
      spi_phase_e phase;
      logic sck_prev;
      logic [2:0] bit_cnt;
      logic is_write;
      logic [6:0] addr;
      logic [7:0] in_shift;
      logic [7:0] rd_shift;
      logic sdo;
      logic sdo_oe_n;
      logic [7:0] rate_lo;
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic [7:0] dev_lo;
      logic [9:0] ofs;
      logic [8:0] pn9;
      logic [8:0] white;
      logic [15:0] rate_word;
      logic [8:0] dev_word;
      logic [10:0] ofs_scaled;
      logic ph_pwdn;
      logic tx_bit;
      logic rx_bit;
      logic txclk_gpio;
      logic irq_pin;
   } regs_s;

endpackage

//--- design/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for the port pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   A change is accepted only once stages two and three agree.
`timescale 1ns/10ps
module pin_sync (
   input wire logic clk, // System clock.
   input wire logic resetn, // Synchronous reset, active low.
   input wire logic [2:0] pin_in, // Raw pins: chip select, serial clock, data in.
   input wire logic [2:0] idle_val, // Level each bit shows after reset.
   output logic [2:0] pin_out // Filtered, synchronised levels.
);
   import tx_mod_pkg::*;

   sync_s q;
   sync_s d;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   // Stage one is read only by stage two, so metastability stays contained.
   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Agreeing stages set the level; a disagreement holds the last one.
      d.stable = (q.s2 & q.s3) | (q.stable & (q.s2 ^ q.s3));
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   // Reset loads the idle levels, so no false edge follows reset.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= {4{idle_val}};
      end else begin
         q <= d;
      end
   end

   assign pin_out = q.stable;
endmodule

//--- dv/tx_mod_props.sv
// Purpose: Port checks of the modem configuration registers.
// Assumes: Outputs trail inputs by one clock, except out enable, which trails select through the pin synchroniser.
// Notes:   Bound into the design after the module.
`timescale 1ns/10ps
module tx_mod_props (
   input wire logic clk, // Clock.
   input wire logic resetn, // Reset.
   input wire logic chip_select_pin_n, // Select.
   input wire logic sdo_oe_n, // Out enable.
   input wire logic [7:0] tx_rate_high, // Rate high.
   input wire logic high_band, // Band.
   input wire logic low_power_mode, // Low power.
   input wire logic tx_clk_level, // Tx clock.
   input wire logic rx_data_in, // Rx in.
   input wire logic irq_source_n, // Irq in.
   input wire logic [15:0] tx_rate_word, // Rate word.
   input wire logic ph_power_down, // Power-down.
   input wire tx_mod_pkg::trclk_e trclk_sel, // Routing.
   input wire logic [9:0] offset_value, // Offset.
   input wire logic [10:0] offset_scaled, // Scaled.
   input wire logic rx_data_out, // Rx out.
   input wire logic txclk_gpio, // Gpio clock.
   input wire logic interrupt_pin_n // Irq pin.
);
   import tx_mod_pkg::*;
   // Single clock domain.
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_rate_high;
      1'b1 |=> tx_rate_word[15:8] == $past(tx_rate_high);
   endproperty
   a_rate_high: assert property (p_rate_high) else $error("rate high wrong");
   property p_ph_awake;
      !low_power_mode |=> !ph_power_down;
   endproperty
   a_ph_awake: assert property (p_ph_awake) else $error("handler down awake");
   property p_rx_follow;
      !$stable(rx_data_in) |=> !$stable(rx_data_out);
   endproperty
   a_rx_follow: assert property (p_rx_follow) else $error("rx bit stuck");
   property p_clk_gpio;
      trclk_sel == TRCLK_GPIO |=> txclk_gpio == $past(tx_clk_level);
   endproperty
   a_clk_gpio: assert property (p_clk_gpio) else $error("gpio clock wrong");
   property p_clk_irq;
      trclk_sel == TRCLK_IRQ |=> interrupt_pin_n == $past(tx_clk_level);
   endproperty
   a_clk_irq: assert property (p_clk_irq) else $error("irq pin clock wrong");
   property p_irq_plain;
      trclk_sel != TRCLK_IRQ |=> interrupt_pin_n == $past(irq_source_n)
         && (!txclk_gpio || $past(trclk_sel) == TRCLK_GPIO);
   endproperty
   a_irq_plain: assert property (p_irq_plain) else $error("irq pin source wrong");
   property p_ofs_high;
      high_band |=> offset_scaled == {$past(offset_value), 1'b0};
   endproperty
   a_ofs_high: assert property (p_ofs_high) else $error("high offset wrong");
   property p_ofs_low;
      !high_band |=> offset_scaled[9:0] == $past(offset_value)
         && offset_scaled[10] == offset_scaled[9];
   endproperty
   a_ofs_low: assert property (p_ofs_low) else $error("low offset wrong");
   property p_sdo_clk;
      (chip_select_pin_n && trclk_sel == TRCLK_SDO) [*8] |-> !sdo_oe_n;
   endproperty
   a_sdo_clk: assert property (p_sdo_clk) else $error("sdo clock idle");
   property p_sdo_sel;
      $fell(chip_select_pin_n) |-> ##[1:8] !sdo_oe_n;
   endproperty
   a_sdo_sel: assert property (p_sdo_sel) else $error("sdo idle in frame");
endmodule

bind tx_modulation_config_regs tx_mod_props tx_mod_props_inst (.clk(clk), .resetn(resetn),
   .chip_select_pin_n(chip_select_pin_n), .sdo_oe_n(sdo_oe_n), .tx_rate_high(tx_rate_high),
   .high_band(high_band), .low_power_mode(low_power_mode), .tx_clk_level(tx_clk_level),
   .rx_data_in(rx_data_in), .irq_source_n(irq_source_n), .tx_rate_word(tx_rate_word),
   .ph_power_down(ph_power_down), .trclk_sel(trclk_sel), .offset_value(offset_value),
   .offset_scaled(offset_scaled), .rx_data_out(rx_data_out), .txclk_gpio(txclk_gpio),
   .interrupt_pin_n(interrupt_pin_n));

//--- dv/host_model.sv
// Purpose: Host on the serial register port.
// Assumes: Mode 0, MSB first, 64 ns serial clock period.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/10ps
module host_model (
   output logic chip_select_pin_n, // Select.
   output logic sck_pin, // Serial clock.
   output logic sdi_pin, // Data to the device.
   input wire logic sdo_pin, // Data from the device.
   input wire logic sdo_oe_n // Out enable.
);
   // Idle levels.
   initial begin
      chip_select_pin_n = 1'b1;
      sck_pin = 1'b0;
      sdi_pin = 1'b0;
   end

   // Sample late: sdo settles clocks after a fall.
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sdi_pin = tx[i];
         #32 sck_pin = 1'b1;
         #28 rx[i] = sdo_oe_n ? 1'bx : sdo_pin;
         #4 sck_pin = 1'b0;
      end
   endtask

   // Burst of n bytes; gap between bytes.
   task automatic frame(input logic wr, input logic [6:0] addr, input int n, input int gap,
                        input logic [7:0] wd [4], output logic [7:0] rd [4]);
      logic [7:0] junk;
      chip_select_pin_n = 1'b0;
      #40;
      shift_byte({wr, addr}, junk);
      for (int k = 0; k < n; k++) begin
         #(gap);
         shift_byte(wd[k], rd[k]);
      end
      #40 chip_select_pin_n = 1'b1;
      sdi_pin = ~sdi_pin; // Released line drifts.
      #120;
   endtask
endmodule

//--- dv/tx_modulation_config_regs_tb_top.sv
// Purpose: Self-checking bench of the modem configuration registers.
// Assumes: Host model drives the serial port.
// Notes:   Inputs move 1 ns after the rising clock edge.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
   $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tx_modulation_config_regs_tb_top;
   import tx_mod_pkg::*;
   logic clk, resetn, chip_select_pin_n, sck_pin, sdi_pin, sdo_pin, sdo_oe_n;
   logic high_band, low_power_mode, tx_bit_strobe, tx_clk_level, preamble_phase;
   logic gpio_tx_data, fifo_tx_data, rx_data_in, irq_source_n, rate_scale, ph_power_down;
   logic manchester_en, whiten_en, tx_data_out, rx_data_out, txclk_gpio, interrupt_pin_n;
   logic [7:0] tx_rate_high;
   logic [9:0] afc_result, offset_value;
   logic [15:0] tx_rate_word;
   logic [8:0] deviation_value;
   logic [10:0] offset_scaled;
   modtyp_e mod_type;
   trclk_e trclk_sel;
   dtmod_e dtmod_sel;
   int err_total, check_count;
   logic [7:0] wb [4];
   logic [7:0] rb [4];

   tx_modulation_config_regs tx_modulation_config_regs_inst (.clk(clk), .resetn(resetn),
      .chip_select_pin_n(chip_select_pin_n), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
      .sdo_pin(sdo_pin), .sdo_oe_n(sdo_oe_n), .tx_rate_high(tx_rate_high),
      .high_band(high_band), .low_power_mode(low_power_mode), .afc_result(afc_result),
      .tx_bit_strobe(tx_bit_strobe), .tx_clk_level(tx_clk_level),
      .preamble_phase(preamble_phase), .gpio_tx_data(gpio_tx_data),
      .fifo_tx_data(fifo_tx_data), .rx_data_in(rx_data_in), .irq_source_n(irq_source_n),
      .tx_rate_word(tx_rate_word), .rate_scale(rate_scale), .ph_power_down(ph_power_down),
      .manchester_en(manchester_en), .whiten_en(whiten_en), .mod_type(mod_type),
      .trclk_sel(trclk_sel), .dtmod_sel(dtmod_sel), .deviation_value(deviation_value),
      .offset_value(offset_value), .offset_scaled(offset_scaled),
      .tx_data_out(tx_data_out), .rx_data_out(rx_data_out), .txclk_gpio(txclk_gpio),
      .interrupt_pin_n(interrupt_pin_n));
   host_model host_model_inst (.chip_select_pin_n(chip_select_pin_n), .sck_pin(sck_pin),
      .sdi_pin(sdi_pin), .sdo_pin(sdo_pin), .sdo_oe_n(sdo_oe_n));

   // Clock; tx clock toggles each cycle.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      tx_clk_level <= #1 ~tx_clk_level;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      wb[0] = d;
      host_model_inst.frame(1'b1, a, 1, 0, wb, rb);
      step(2);
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] ex);
      host_model_inst.frame(1'b0, a, 1, 0, wb, rb);
      `CHK("read", ex, rb[0])
   endtask
   task automatic wrap_up();
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset_vals();
      rchk(7'h6F, 8'h0D);
      rchk(7'h70, 8'h0C);
      rchk(7'h71, 8'h00);
      rchk(7'h72, 8'h20);
      rchk(7'h73, 8'hA5);
      rchk(7'h74, 8'h02);
      `CHK("rate word", 16'h0A0D, tx_rate_word)
      `CHK("rate scale", 1'b0, rate_scale)
      `CHK("deviation", 9'h020, deviation_value)
   endtask
   // Slow burst; low rate sets scale.
   task automatic t_regs();
      wb = '{8'h40, 8'hFF, 8'h00, 8'h28};
      host_model_inst.frame(1'b1, 7'h6F, 4, 200, wb, rb);
      step(2);
      `CHK("rate word", 16'h0A40, tx_rate_word)
      `CHK("rate scale", 1'b1, rate_scale)
      `CHK("handler down", 1'b0, ph_power_down)
      low_power_mode = 1'b1;
      step(2);
      `CHK("handler down", 1'b1, ph_power_down)
      low_power_mode = 1'b0;
      `CHK("whitening", 1'b1, whiten_en)
      `CHK("manchester", 1'b1, manchester_en)
      host_model_inst.frame(1'b0, 7'h6F, 4, 0, wb, rb);
      `CHK("burst ctl1", 8'h3F, rb[1])
      `CHK("burst dev", 8'h28, rb[3])
      rchk(7'h75, 8'h00);
      wr(7'h70, 8'h00);
      wr(7'h71, 8'h04);
      `CHK("deviation", 9'h128, deviation_value)
   endtask
   task automatic t_offset();
      wb = '{8'h80, 8'hFF, 8'h00, 8'h00};
      host_model_inst.frame(1'b1, 7'h73, 2, 0, wb, rb);
      step(2);
      `CHK("offset", 10'h380, offset_value)
      `CHK("offset scaled", 11'h780, offset_scaled)
      high_band = 1'b1;
      step(2);
      `CHK("offset scaled", 11'h700, offset_scaled)
      high_band = 1'b0;
      afc_result = 10'h15A;
      rchk(7'h73, 8'h5A);
      rchk(7'h74, 8'h01);
   endtask
   // All selector codes.
   task automatic t_fields();
      logic [1:0] t, d, m;
      for (int i = 0; i < 4; i++) begin
         t = i[1:0];
         d = t + 2'd1;
         m = t + 2'd2;
         wr(7'h71, {t, d, 2'b00, m});
         `CHK("clock route", t, trclk_sel)
         `CHK("data source", d, dtmod_sel)
         `CHK("mod type", m, mod_type)
         rchk(7'h71, {t, d, 2'b00, m});
      end
   endtask
   task automatic pre_chk(input logic [7:0] c1, input logic src, input logic ex);
      wr(7'h70, c1);
      fifo_tx_data = src;
      preamble_phase = 1'b1;
      step(4);
      `CHK("preamble bit", ex, tx_data_out)
      preamble_phase = 1'b0;
   endtask
   task automatic t_datapath();
      fifo_tx_data = 1'b1;
      wr(7'h71, 8'h20);
      wr(7'h70, 8'h02);
      `CHK("tx bit", 1'b1, tx_data_out)
      wr(7'h70, 8'h06);
      `CHK("tx bit", 1'b0, tx_data_out)
      wr(7'h70, 8'h04);
      `CHK("tx bit", 1'b1, tx_data_out)
      wr(7'h71, 8'h28);
      `CHK("tx bit", 1'b0, tx_data_out)
      rx_data_in = 1'b1;
      step(2);
      `CHK("rx bit", 1'b0, rx_data_out)
      wr(7'h71, 8'h20);
      wr(7'h70, 8'h01);
      `CHK("tx bit", 1'b0, tx_data_out)
      pre_chk(8'h0A, 1'b0, 1'b1);
      pre_chk(8'h02, 1'b1, 1'b0);
      pre_chk(8'h08, 1'b0, 1'b0);
   endtask

   // -------------------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------------------
   initial begin
      err_total = 0;
      check_count = 0;
      resetn = 1'b0;
      tx_rate_high = 8'h0A;
      {high_band, low_power_mode, tx_bit_strobe, preamble_phase} = 4'h0;
      {gpio_tx_data, fifo_tx_data, rx_data_in, tx_clk_level} = 4'h0;
      irq_source_n = 1'b1;
      afc_result = 10'h2A5;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      step(8);
      t_reset_vals();
      t_regs();
      t_offset();
      t_fields();
      t_datapath();
      wrap_up();
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule
